// ### core/sld_defines.svh
// Constants for the serial latched source driver core
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH
`define SLD_WIDTH 10
`define SLD_CLK_NS 10
`define SLD_MAX_SCLK_KHZ 10000
`endif

// ### core/sld_pkg.sv
// Types for the serial latched source driver core
package sld_pkg;
  // Serial control inputs sampled from the controller
  typedef struct packed {
    logic sdata;
    logic sclk;
    logic strobe;
    logic blank;
  } sld_ctl_t;
  // Edge tracker states
  typedef enum logic [1:0] {
    SLD_CLK_LOW = 2'b01,
    SLD_CLK_HIGH = 2'b10
  } sld_edge_t;
endpackage

// ### core/sld_core.sv
// Serial-in shift register, transparent latches and blanked output stage
`timescale 1ns/1ps
`include "sld_defines.svh"
module sld_core #(
  parameter int WIDTH = `SLD_WIDTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Controller inputs
  input wire sld_pkg::sld_ctl_t ctl,
  // Cascade and parallel outputs
  output logic sdo,
  output logic [WIDTH-1:0] src_on,
  output logic [WIDTH-1:0] sink_on
);
  import sld_pkg::*;

  sld_edge_t edge_ff, nxt_edge;
  logic [WIDTH-1:0] shift_ff, nxt_shift;
  logic [WIDTH-1:0] latch_ff, nxt_latch;
  logic sdo_ff, nxt_sdo;
  logic [WIDTH-1:0] src_ff, nxt_src;
  logic [WIDTH-1:0] sink_ff, nxt_sink;
  logic rise;

  // Rising edge of the shift clock seen at mclk rate; sclk must be well under mclk
  assign rise = (edge_ff == SLD_CLK_LOW) && ctl.sclk;

  // Shift register and edge tracking
  always_comb begin
    nxt_edge = ctl.sclk ? SLD_CLK_HIGH : SLD_CLK_LOW;
    nxt_shift = shift_ff;
    if (rise) begin
      nxt_shift = {shift_ff[WIDTH-2:0], ctl.sdata};
    end
    nxt_sdo = nxt_shift[WIDTH-1];
  end

  // Latches track the register image while strobe is high
  always_comb begin
    nxt_latch = ctl.strobe ? nxt_shift : latch_ff;
  end

  // Output stage: blanking only masks, never writes latches
  always_comb begin
    case (ctl.blank)
      1'b1: begin
        nxt_src = '0;
        nxt_sink = '1;
      end
      default: begin
        nxt_src = nxt_latch;
        nxt_sink = ~nxt_latch;
      end
    endcase
  end

  // Registers; a reset pin does not exist on the part, so this is for simulation order
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_ff <= SLD_CLK_HIGH;
      shift_ff <= '0;
      latch_ff <= '0;
      sdo_ff <= 1'b0;
      src_ff <= '0;
      sink_ff <= '1;
    end else begin
      edge_ff <= nxt_edge;
      shift_ff <= nxt_shift;
      latch_ff <= nxt_latch;
      sdo_ff <= nxt_sdo;
      src_ff <= nxt_src;
      sink_ff <= nxt_sink;
    end
  end

  assign sdo = sdo_ff;
  assign src_on = src_ff;
  assign sink_on = sink_ff;

  // Checks
  property p_shift_in;
    @(posedge mclk) disable iff (!rst_n)
      rise |=> shift_ff[0] == $past(ctl.sdata);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not captured");

  property p_shift_move;
    @(posedge mclk) disable iff (!rst_n)
      rise |=> shift_ff[WIDTH-1:1] == $past(shift_ff[WIDTH-2:0]) && sdo == shift_ff[WIDTH-1];
  endproperty
  a_shift_move: assert property (p_shift_move) else $error("shift did not advance");

  property p_hold_noedge;
    @(posedge mclk) disable iff (!rst_n)
      !rise |=> $stable(shift_ff);
  endproperty
  a_hold_noedge: assert property (p_hold_noedge) else $error("shift without clock rise");

  property p_latch_follow;
    @(posedge mclk) disable iff (!rst_n)
      ctl.strobe |=> latch_ff == shift_ff;
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("latch not transparent");

  property p_latch_hold;
    @(posedge mclk) disable iff (!rst_n)
      !ctl.strobe |=> $stable(latch_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed with strobe low");

  property p_blank_off;
    @(posedge mclk) disable iff (!rst_n)
      ctl.blank |=> src_on == '0 && sink_on == '1;
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("blanking did not disable outputs");

  property p_blank_keep;
    @(posedge mclk) disable iff (!rst_n)
      (ctl.blank && !ctl.strobe) |=> $stable(latch_ff);
  endproperty
  a_blank_keep: assert property (p_blank_keep) else $error("blanking disturbed latches");

  property p_out_follow;
    @(posedge mclk) disable iff (!rst_n)
      !ctl.blank |=> src_on == latch_ff && sink_on == ~latch_ff;
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("output not from latch");

  // Cascade pin always mirrors the last stage
  property p_sdo_track;
    @(posedge mclk) disable iff (!rst_n)
      sdo == shift_ff[WIDTH-1];
  endproperty
  a_sdo_track: assert property (p_sdo_track) else $error("cascade output not last stage");

  // A rise moves the next-to-last stage onto the cascade pin
  property p_sdo_next;
    @(posedge mclk) disable iff (!rst_n)
      rise |=> sdo == $past(shift_ff[WIDTH-2]);
  endproperty
  a_sdo_next: assert property (p_sdo_next) else $error("cascade output skipped a stage");

  // Cascade pin quiet between rises, so a far device sees clean data
  property p_sdo_hold;
    @(posedge mclk) disable iff (!rst_n)
      !rise |=> $stable(sdo);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("cascade output moved without rise");

  // A long high phase must count as one rise only
  property p_rise_single;
    @(posedge mclk) disable iff (!rst_n)
      rise |=> !rise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("one clock rise shifted twice");

  // Edge tracker stays in a legal one-hot state
  property p_edge_onehot;
    @(posedge mclk) disable iff (!rst_n)
      $onehot(edge_ff);
  endproperty
  a_edge_onehot: assert property (p_edge_onehot) else $error("edge tracker state illegal");

  // Blanking must not stop a strobe from loading the latches
  property p_blank_strobe;
    @(posedge mclk) disable iff (!rst_n)
      (ctl.blank && ctl.strobe) |=> latch_ff == shift_ff;
  endproperty
  a_blank_strobe: assert property (p_blank_strobe) else $error("blanking blocked latch load");

  // Source and sink never on together; a clash would short the load supply
  property p_out_excl;
    @(posedge mclk) disable iff (!rst_n)
      (src_on & sink_on) == '0;
  endproperty
  a_out_excl: assert property (p_out_excl) else $error("source and sink both on");

  // Unblanked sinks are the exact complement of the sources
  property p_sink_comp;
    @(posedge mclk) disable iff (!rst_n)
      !ctl.blank |=> sink_on == ~src_on;
  endproperty
  a_sink_comp: assert property (p_sink_comp) else $error("sink not complement of source");

  // Leaving blanking restores the stored pattern at once
  property p_unblank;
    @(posedge mclk) disable iff (!rst_n)
      (!ctl.blank && $past(ctl.blank)) |=> src_on == latch_ff;
  endproperty
  a_unblank: assert property (p_unblank) else $error("pattern lost across blanking");

  // Strobe low and blank low: outputs show the held latch value
  property p_strobe_low_out;
    @(posedge mclk) disable iff (!rst_n)
      (!ctl.strobe && !ctl.blank) |=> src_on == $past(latch_ff);
  endproperty
  a_strobe_low_out: assert property (p_strobe_low_out) else $error("output left held latch");

  // Transparent latch picks up a bit shifted in the same cycle
  property p_latch_from_shift;
    @(posedge mclk) disable iff (!rst_n)
      (ctl.strobe && rise) |=> latch_ff[0] == $past(ctl.sdata);
  endproperty
  a_latch_from_shift: assert property (p_latch_from_shift) else $error("latch missed new bit");

  // Held latches keep the sinks steady too
  property p_sink_hold;
    @(posedge mclk) disable iff (!rst_n)
      (!ctl.blank && !ctl.strobe) |=> sink_on == ~$past(latch_ff);
  endproperty
  a_sink_hold: assert property (p_sink_hold) else $error("sink left held latch");
endmodule

// ### verification/sld_ctl_model.sv
// Controller model that shifts words into the driver core
`timescale 1ns/1ps
module sld_ctl_model (
  // Clock
  input wire logic mclk,
  // Lines toward the core
  output sld_pkg::sld_ctl_t ctl
);
  import sld_pkg::*;
  // Idle lines until the first word
  initial ctl = '0;
  // First bit out is w[9]; five mclk per phase keeps sclk at 10 MHz
  task automatic send(input logic [9:0] w, input logic s, input logic b);
    for (int i = 9; i >= 0; i--) begin
      ctl <= '{sdata: w[i], sclk: 1'b0, strobe: 1'b0, blank: b};
      repeat (5) @(posedge mclk);
      #1 ctl.sclk <= 1'b1;
      repeat (5) @(posedge mclk);
      #1;
    end
    // Data line released to the inverse so a stale bit cannot pass
    ctl <= '{sdata: ~w[0], sclk: 1'b0, strobe: s, blank: b};
    repeat (5) @(posedge mclk);
    #1 ctl.strobe <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the serial latched driver core
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
  import sld_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  sld_ctl_t ctl;
  logic sdo;
  logic [9:0] src_on, sink_on, w, lat;
  logic [31:0] seed = 32'h71d0a93d;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  sld_core uut (.mclk(mclk), .rst_n(rst_n), .ctl(ctl), .sdo(sdo), .src_on(src_on), .sink_on(sink_on));
  sld_ctl_model ctl_m (.mclk(mclk), .ctl(ctl));
  // 100 MHz clock
  always #5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Blanking forces sources off and sinks on, else outputs follow latches
  function automatic logic [19:0] exp_out(input logic b, input logic [9:0] l);
    return b ? {10'h000, 10'h3ff} : {l, ~l};
  endfunction
  task automatic check(input logic b, input logic [9:0] l, input logic d);
    `CHK("src_sink", exp_out(b, l), {src_on, sink_on})
    `CHK("sdo", d, sdo)
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycle ceiling against a hang; a full run takes about 1200
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // Corner and random words, then hold, blanking and unblanking cases
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    check(1'b0, 10'h000, 1'b0);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      w = (k == 0) ? 10'h3ff : (k == 1) ? 10'h200 : seed[9:0];
      ctl_m.send(w, 1'b1, 1'b0);
      check(1'b0, w, w[9]);
    end
    lat = w;
    seed = xs(seed);
    w = seed[9:0];
    ctl_m.send(w, 1'b0, 1'b0);
    check(1'b0, lat, w[9]);
    ctl_m.send(w, 1'b1, 1'b1);
    check(1'b1, w, w[9]);
    lat = w;
    w = ~w;
    ctl_m.send(w, 1'b0, 1'b0);
    check(1'b0, lat, w[9]);
    report_and_stop();
  end
endmodule
